// [rtl/ssc_pkg.sv]
// Contract
// - Three-wire command is one 32-bit word.
// - Two-wire command is address plus 32 bits.
// - Factory presets held until master reloads.
// - Channel write sets start plus channel times step.
// - Grounded clock pin selects two-wire mode.
// - Device only receives, drives bus to acknowledge.
// - Address byte: 7-bit address then direction.
// - Master always sends direction bit zero.
// - Accept only own base address plus variant.
// - Two-wire command is five single bytes.
// - START opens command; device acknowledges every byte.
// - Commit only on STOP after fifth byte.
// - New START before STOP discards partial command.
// - Master never uses repeated START.
// - First data byte packs route and exponent.
// - Value field spans last three data bytes.
// - Value field is unsigned hertz or channel.
// - Value scaled by ten to the exponent.
// - Route 31:28, exponent 27:24, value 23:0.
// - Codes 0-4 route channel/start/stop/step/reference.
// - Pins are select/data/clock or data/clock/mode.
package ssc_pkg;
   localparam int CMD_W        = 32;
   localparam int VAL_W        = 24;
   localparam int REG_W        = 75;
   localparam int ROUTE_HI     = 31;
   localparam int ROUTE_LO     = 28;
   localparam int EXP_HI       = 27;
   localparam int EXP_LO       = 24;
   localparam int VAL_HI       = 23;
   localparam int I2C_BYTES    = 5;
   localparam int BYTE_BITS    = 8;

   localparam logic [3:0] ROUTE_CHANNEL = 4'h0;
   localparam logic [3:0] ROUTE_START   = 4'h1;
   localparam logic [3:0] ROUTE_STOP    = 4'h2;
   localparam logic [3:0] ROUTE_STEP    = 4'h3;
   localparam logic [3:0] ROUTE_REF     = 4'h4;

   localparam logic [REG_W-1:0] START_RST   = 75'h0_0000_0000_3B9A_CA00;
   localparam logic [REG_W-1:0] STOP_RST    = 75'h0_0000_0000_7735_9400;
   localparam logic [REG_W-1:0] STEP_RST    = 75'h0_0000_0000_000F_4240;
   localparam logic [REG_W-1:0] REF_RST     = 75'h0_0000_0000_0131_2D00;
   localparam logic [REG_W-1:0] CHANNEL_RST = 75'h0_0000_0000_0000_0000;

   // Arbitrary base address
   localparam logic [6:0] I2C_BASE_ADDR = 7'h40;

   localparam int CLK_NS        = 5;
   localparam int LINK_HALF_NS  = 250;
   localparam int LINK_HALF_CYC = (LINK_HALF_NS + CLK_NS - 1) / CLK_NS;

   localparam logic [7:0] REG_CMD    = 8'h00;
   localparam logic [7:0] REG_CTRL   = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam int CTRL_GO      = 0;
   localparam int CTRL_I2C     = 1;
   localparam int CTRL_ADDR_LO = 8;
   localparam int STATUS_BUSY  = 0;
   localparam int STATUS_NACK  = 1;

   typedef enum logic [3:0] {
      DS_IDLE = 4'b0001,
      DS_RX   = 4'b0010,
      DS_ACK  = 4'b0100,
      DS_END  = 4'b1000
   } ssc_dev_st_t;

   typedef enum logic [3:0] {
      HS_IDLE = 4'b0001,
      HS_LEAD = 4'b0010,
      HS_BITS = 4'b0100,
      HS_TAIL = 4'b1000
   } ssc_host_st_t;
endpackage

// [rtl/ssc_link_if.sv]
`timescale 1ns/1ps
interface ssc_link_if;
   logic host_sel_data_o;
   logic host_sel_data_oe_n;
   logic host_in_clock_o;
   logic host_in_clock_oe_n;
   logic host_clock_mode_o;
   logic dev_sel_data_o;
   logic dev_sel_data_oe_n;
   logic select_or_i2c_data_pin;
   logic serial_in_or_i2c_clock_pin;
   logic serial_clock_or_mode_pin;

   // Data and clock wires pulled up, any enabled low driver wins; mode wire driven by host only
   assign select_or_i2c_data_pin     = (host_sel_data_oe_n | host_sel_data_o) & (dev_sel_data_oe_n | dev_sel_data_o);
   assign serial_in_or_i2c_clock_pin = host_in_clock_oe_n | host_in_clock_o;
   assign serial_clock_or_mode_pin   = host_clock_mode_o;

   modport host (
      output host_sel_data_o,
      output host_sel_data_oe_n,
      output host_in_clock_o,
      output host_in_clock_oe_n,
      output host_clock_mode_o,
      input  select_or_i2c_data_pin,
      input  serial_in_or_i2c_clock_pin,
      input  serial_clock_or_mode_pin
   );
   modport dev (
      output dev_sel_data_o,
      output dev_sel_data_oe_n,
      input  select_or_i2c_data_pin,
      input  serial_in_or_i2c_clock_pin,
      input  serial_clock_or_mode_pin
   );
endinterface

// [rtl/ssc_dev.sv]
`timescale 1ns/1ps
module ssc_dev
   import ssc_pkg::*;
#(
   parameter logic [1:0] ADDR_VARIANT = 2'h0
) (
   input  wire logic             clk,
   input  wire logic             resetn,
   ssc_link_if.dev               link,
   output      logic [REG_W-1:0] start_hz,
   output      logic [REG_W-1:0] stop_hz,
   output      logic [REG_W-1:0] step_hz,
   output      logic [REG_W-1:0] ref_hz,
   output      logic [REG_W-1:0] channel_num,
   output      logic [REG_W-1:0] freq_hz,
   output      logic             update,
   output      logic             reserved_code
);
   typedef struct packed {
      logic [2:0]       s1;
      logic [2:0]       s2;
      logic [2:0]       s3;
      logic             i2c_mode;
      ssc_dev_st_t      st;
      logic [5:0]       bitcnt;
      logic [2:0]       bytecnt;
      logic [CMD_W-1:0] shreg;
      logic             ack;
      logic             busy;
      logic [3:0]       exp_left;
      logic [3:0]       route;
      logic [REG_W-1:0] acc;
      logic [REG_W-1:0] start_hz;
      logic [REG_W-1:0] stop_hz;
      logic [REG_W-1:0] step_hz;
      logic [REG_W-1:0] ref_hz;
      logic [REG_W-1:0] chan;
      logic [REG_W-1:0] freq;
      logic             update;
      logic             reserved;
   } ssc_dev_state_t;

   localparam logic [6:0] OWN_ADDR = I2C_BASE_ADDR + {5'h00, ADDR_VARIANT};

   function automatic logic [REG_W-1:0] mul10(input logic [REG_W-1:0] v);
      mul10 = (v << 3) + (v << 1);
   endfunction

   ssc_dev_state_t r;
   ssc_dev_state_t next_r;
   logic           scl_rise;
   logic           scl_fall;
   logic           bus_start;
   logic           bus_stop;
   logic           ck_rise;
   logic           cs_rise;
   logic           cs_fall;
   logic           commit;

   always_comb begin
      next_r    = r;
      commit    = 1'b0;
      next_r.s1 = {link.serial_clock_or_mode_pin, link.serial_in_or_i2c_clock_pin, link.select_or_i2c_data_pin};
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      next_r.update   = 1'b0;
      next_r.reserved = 1'b0;
      scl_rise  = r.s2[1] & ~r.s3[1];
      scl_fall  = ~r.s2[1] & r.s3[1];
      bus_start = ~r.s2[0] & r.s3[0] & r.s2[1] & r.s3[1];
      bus_stop  = r.s2[0] & ~r.s3[0] & r.s2[1] & r.s3[1];
      ck_rise   = r.s2[2] & ~r.s3[2];
      cs_rise   = r.s2[0] & ~r.s3[0];
      cs_fall   = ~r.s2[0] & r.s3[0];
      // Mode follows the clock pin only while the link is idle
      if (r.s2[0] && r.st == DS_IDLE && r.bitcnt == 6'h00) begin
         next_r.i2c_mode = ~r.s2[2];
      end
      if (!r.i2c_mode) begin
         next_r.st  = DS_IDLE;
         next_r.ack = 1'b0;
         if (cs_fall || cs_rise) begin
            next_r.bitcnt = 6'h00;
         end else if (!r.s2[0] && ck_rise) begin
            next_r.shreg = {r.shreg[CMD_W-2:0], r.s2[1]};
            if (r.bitcnt != 6'h21) begin
               next_r.bitcnt = r.bitcnt + 6'h01;
            end
         end
         if (cs_rise && r.bitcnt == 6'(CMD_W)) begin
            commit = 1'b1;
         end
      end else if (bus_start) begin
         next_r.st      = DS_RX;
         next_r.bitcnt  = 6'h00;
         next_r.bytecnt = 3'h0;
         next_r.ack     = 1'b0;
      end else if (bus_stop) begin
         next_r.st  = DS_IDLE;
         next_r.ack = 1'b0;
         commit     = (r.st == DS_END);
      end else begin
         case (r.st)
            DS_RX: begin
               if (scl_rise && r.bitcnt != 6'(BYTE_BITS)) begin
                  next_r.shreg  = {r.shreg[CMD_W-2:0], r.s2[0]};
                  next_r.bitcnt = r.bitcnt + 6'h01;
               end else if (scl_fall && r.bitcnt == 6'(BYTE_BITS)) begin
                  if (r.bytecnt == 3'h0 && (r.shreg[7:1] != OWN_ADDR || r.shreg[0])) begin
                     next_r.st = DS_IDLE;
                  end else begin
                     next_r.st  = DS_ACK;
                     next_r.ack = 1'b1;
                  end
               end
            end
            DS_ACK: begin
               if (scl_fall) begin
                  next_r.ack     = 1'b0;
                  next_r.bitcnt  = 6'h00;
                  next_r.bytecnt = r.bytecnt + 3'h1;
                  next_r.st      = (r.bytecnt == 3'(I2C_BYTES - 1)) ? DS_END : DS_RX;
               end
            end
            DS_END: begin
               // Any further clocked bit without STOP discards the word
               if (scl_fall) begin
                  next_r.st = DS_IDLE;
               end
            end
            default: begin
               next_r.st = DS_IDLE;
            end
         endcase
      end
      if (commit) begin
         next_r.busy     = 1'b1;
         next_r.route    = r.shreg[ROUTE_HI:ROUTE_LO];
         next_r.exp_left = r.shreg[EXP_HI:EXP_LO];
         next_r.acc      = {{(REG_W-VAL_W){1'b0}}, r.shreg[VAL_HI:0]};
      end else if (r.busy) begin
         if (r.exp_left != 4'h0) begin
            next_r.acc      = mul10(r.acc);
            next_r.exp_left = r.exp_left - 4'h1;
         end else begin
            next_r.busy   = 1'b0;
            next_r.update = 1'b1;
            case (r.route)
               ROUTE_CHANNEL: next_r.chan     = r.acc;
               ROUTE_START:   next_r.start_hz = r.acc;
               ROUTE_STOP:    next_r.stop_hz  = r.acc;
               ROUTE_STEP:    next_r.step_hz  = r.acc;
               ROUTE_REF:     next_r.ref_hz   = r.acc;
               default: begin
                  next_r.update   = 1'b0;
                  next_r.reserved = 1'b1;
               end
            endcase
         end
      end
      next_r.freq = r.start_hz + REG_W'(r.chan * r.step_hz);
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         r          <= '0;
         r.s1       <= 3'h3;
         r.s2       <= 3'h3;
         r.s3       <= 3'h3;
         r.st       <= DS_IDLE;
         r.start_hz <= START_RST;
         r.stop_hz  <= STOP_RST;
         r.step_hz  <= STEP_RST;
         r.ref_hz   <= REF_RST;
         r.chan     <= CHANNEL_RST;
         r.freq     <= START_RST;
      end else begin
         r <= next_r;
      end
   end

   assign link.dev_sel_data_o    = 1'b0;
   assign link.dev_sel_data_oe_n = ~r.ack;
   assign start_hz      = r.start_hz;
   assign stop_hz       = r.stop_hz;
   assign step_hz       = r.step_hz;
   assign ref_hz        = r.ref_hz;
   assign channel_num   = r.chan;
   assign freq_hz       = r.freq;
   assign update        = r.update;
   assign reserved_code = r.reserved;
endmodule // ssc_dev

// [rtl/ssc_host.sv]
`timescale 1ns/1ps
module ssc_host
   import ssc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        resetn,
   ssc_link_if.host         link,
   input  wire logic        wb_cyc,
   input  wire logic        wb_stb,
   input  wire logic        wb_we,
   input  wire logic [7:0]  wb_adr,
   input  wire logic [3:0]  wb_sel,
   input  wire logic [31:0] wb_dat_w,
   output      logic [31:0] wb_dat_r,
   output      logic        wb_ack
);
   typedef struct packed {
      logic         ack;
      logic [31:0]  rdata;
      logic [31:0]  cmd;
      logic         i2c_mode;
      logic [6:0]   addr;
      logic         busy;
      logic         nack;
      ssc_host_st_t st;
      logic [5:0]   div;
      logic [1:0]   phase;
      logic [3:0]   bitix;
      logic [2:0]   byteix;
      logic [39:0]  shreg;
      logic         p0;
      logic         p1;
      logic         p2;
      logic [1:0]   sda_sync;
   } ssc_host_state_t;

   function automatic logic [31:0] sel_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
      for (int i = 0; i < 4; i++) begin
         sel_merge[i*8 +: 8] = sel[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
      end
   endfunction

   ssc_host_state_t r;
   ssc_host_state_t next_r;
   logic            tick;
   logic            wr;
   logic [31:0]     ctrl_v;
   logic [31:0]     wv;
   logic            last_phase;
   logic            ack_slot;

   always_comb begin
      next_r          = r;
      ctrl_v          = 32'h0000_0000;
      ctrl_v[CTRL_I2C] = r.i2c_mode;
      ctrl_v[CTRL_ADDR_LO +: 7] = r.addr;
      next_r.sda_sync = {r.sda_sync[0], link.select_or_i2c_data_pin};
      wr              = wb_cyc & wb_stb & wb_we & r.ack;
      wv              = 32'h0000_0000;
      next_r.ack      = wb_cyc & wb_stb & ~r.ack;
      if (wb_cyc && wb_stb && !r.ack) begin
         if (wb_adr == REG_CMD) begin
            next_r.rdata = r.cmd;
         end else if (wb_adr == REG_CTRL) begin
            next_r.rdata = ctrl_v;
         end else if (wb_adr == REG_STATUS) begin
            next_r.rdata = {30'h0, r.nack, r.busy};
         end else begin
            next_r.rdata = 32'h0000_0000;
         end
      end
      tick       = r.busy && r.div == 6'(LINK_HALF_CYC - 1);
      ack_slot   = r.bitix == 4'(BYTE_BITS);
      last_phase = r.i2c_mode ? r.phase == 2'h2 : r.phase == 2'h1;
      if (r.busy) begin
         next_r.div = tick ? 6'h00 : r.div + 6'h01;
      end
      if (tick) begin
         next_r.phase = last_phase ? 2'h0 : r.phase + 2'h1;
         case (r.st)
            HS_LEAD: begin
               if (!r.i2c_mode) begin
                  next_r.st    = HS_BITS;
                  next_r.phase = 2'h0;
               end else if (r.phase == 2'h0) begin
                  next_r.p0 = 1'b0;
               end else begin
                  next_r.p1    = 1'b0;
                  next_r.st    = HS_BITS;
                  next_r.phase = 2'h0;
               end
            end
            HS_BITS: begin
               if (r.phase == 2'h0) begin
                  next_r.p0 = (r.i2c_mode && ack_slot) ? 1'b1 : r.shreg[39];
                  next_r.p1 = r.i2c_mode ? 1'b0 : r.shreg[39];
                  next_r.p2 = 1'b0;
                  next_r.p0 = r.i2c_mode ? next_r.p0 : 1'b0;
               end else if (r.phase == 2'h1) begin
                  next_r.p1 = r.i2c_mode ? 1'b1 : r.p1;
                  next_r.p2 = 1'b1;
                  if (r.i2c_mode && ack_slot && r.sda_sync[1]) begin
                     next_r.nack = 1'b1;
                  end
               end else begin
                  next_r.p1 = 1'b0;
               end
               if (last_phase) begin
                  if (!(r.i2c_mode && ack_slot)) begin
                     next_r.shreg = {r.shreg[38:0], 1'b0};
                  end
                  if (r.i2c_mode && ack_slot) begin
                     next_r.bitix  = 4'h0;
                     next_r.byteix = r.byteix + 3'h1;
                     if (r.byteix == 3'(I2C_BYTES - 1)) begin
                        next_r.st = HS_TAIL;
                     end
                  end else begin
                     next_r.bitix = r.bitix + 4'h1;
                     if (!r.i2c_mode && r.bitix == 4'h7) begin
                        next_r.bitix  = 4'h0;
                        next_r.byteix = r.byteix + 3'h1;
                        next_r.st     = (r.byteix == 3'h3) ? HS_TAIL : HS_BITS;
                     end
                  end
               end
            end
            HS_TAIL: begin
               if (!r.i2c_mode) begin
                  next_r.p0   = 1'b1;
                  next_r.busy = 1'b0;
                  next_r.st   = HS_IDLE;
               end else if (r.phase == 2'h0) begin
                  next_r.p0 = 1'b0;
               end else if (r.phase == 2'h1) begin
                  next_r.p1 = 1'b1;
               end else begin
                  next_r.p0   = 1'b1;
                  next_r.busy = 1'b0;
                  next_r.st   = HS_IDLE;
               end
            end
            default: begin
               next_r.st = HS_IDLE;
            end
         endcase
      end
      if (wr && wb_adr == REG_STATUS && wb_sel[0] && wb_dat_w[STATUS_NACK] && next_r.nack == r.nack) begin
         next_r.nack = 1'b0;
      end
      if (wr && !r.busy) begin
         if (wb_adr == REG_CMD) begin
            next_r.cmd = sel_merge(r.cmd, wb_dat_w, wb_sel);
         end else if (wb_adr == REG_CTRL) begin
            wv              = sel_merge(ctrl_v, wb_dat_w, wb_sel);
            next_r.i2c_mode = wv[CTRL_I2C];
            next_r.addr     = wv[CTRL_ADDR_LO +: 7];
            next_r.p2       = ~wv[CTRL_I2C];
            if (wv[CTRL_GO]) begin
               next_r.busy   = 1'b1;
               next_r.st     = HS_LEAD;
               next_r.div    = 6'h00;
               next_r.phase  = 2'h0;
               next_r.bitix  = 4'h0;
               next_r.byteix = 3'h0;
               next_r.p0     = wv[CTRL_I2C];
               next_r.p1     = 1'b1;
               if (wv[CTRL_I2C]) begin
                  next_r.shreg = {wv[CTRL_ADDR_LO +: 7], 1'b0, r.cmd};
               end else begin
                  next_r.shreg = {r.cmd, 8'h00};
               end
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         r          <= '0;
         r.addr     <= I2C_BASE_ADDR;
         r.st       <= HS_IDLE;
         r.p0       <= 1'b1;
         r.p1       <= 1'b1;
         r.p2       <= 1'b1;
         r.sda_sync <= 2'h3;
      end else begin
         r <= next_r;
      end
   end

   assign wb_ack                  = r.ack;
   assign wb_dat_r                = r.rdata;
   assign link.host_sel_data_o    = r.p0;
   assign link.host_sel_data_oe_n = r.i2c_mode & r.p0;
   assign link.host_in_clock_o    = r.p1;
   assign link.host_in_clock_oe_n = r.i2c_mode & r.p1;
   assign link.host_clock_mode_o  = ~r.i2c_mode & r.p2;
endmodule // ssc_host

// [dv/ssc_link_monitor.sv]
`timescale 1ns/1ps
module ssc_link_monitor (
   input wire logic clk,
   input wire logic resetn,
   input wire logic host_sel_data_oe_n,
   input wire logic dev_sel_data_o,
   input wire logic dev_sel_data_oe_n,
   input wire logic select_or_i2c_data_pin,
   input wire logic serial_in_or_i2c_clock_pin,
   input wire logic serial_clock_or_mode_pin
);
   logic       cs;
   logic       scl;
   logic       sck;
   logic [5:0] bit_cnt;
   logic [5:0] scl_cnt;
   logic [2:0] ack_cnt;

   assign cs  = select_or_i2c_data_pin;
   assign scl = serial_in_or_i2c_clock_pin;
   assign sck = serial_clock_or_mode_pin;

   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   // Bit, clock and acknowledge counts per frame
   always_ff @(posedge clk) begin
      if (!resetn) begin
         bit_cnt <= 6'h00;
         scl_cnt <= 6'h00;
         ack_cnt <= 3'h0;
      end else begin
         if ($fell(cs)) begin
            bit_cnt <= 6'h00;
         end else if ($rose(sck) && !cs) begin
            bit_cnt <= bit_cnt + 6'h01;
         end
         if ($fell(cs) && scl) begin
            scl_cnt <= 6'h00;
            ack_cnt <= 3'h0;
         end else begin
            if ($rose(scl)) begin
               scl_cnt <= scl_cnt + 6'h01;
            end
            if ($fell(dev_sel_data_oe_n)) begin
               ack_cnt <= ack_cnt + 3'h1;
            end
         end
      end
   end

   sequence s_ack_open; $fell(dev_sel_data_oe_n); endsequence
   sequence s_ack_close; !dev_sel_data_oe_n [*8] ##[12:300] $rose(dev_sel_data_oe_n); endsequence

   property p_low_only; !dev_sel_data_oe_n |-> !dev_sel_data_o; endproperty
   property p_ack_start; s_ack_open |-> !sck && !scl; endproperty
   property p_ack_len; s_ack_open |-> s_ack_close; endproperty
   property p_ack_release; $rose(dev_sel_data_oe_n) |-> !scl; endproperty
   property p_ack_slot; s_ack_open |-> (scl_cnt % 6'h09) == 6'h08; endproperty
   property p_sck_in_frame; $rose(sck) |-> !cs; endproperty
   property p_sck_data; $rose(sck) |-> $stable(scl); endproperty
   property p_word_len; $rose(cs) && sck |-> bit_cnt == 6'h20; endproperty
   property p_i2c_len; $rose(cs) && scl && !sck |-> ack_cnt == 3'h0 || (ack_cnt == 3'h5 && scl_cnt == 6'h2E); endproperty
   property p_ack_host_off; $rose(scl) && !dev_sel_data_oe_n |-> host_sel_data_oe_n; endproperty

   a_low_only: assert property (p_low_only)
      else $error("device drove data pin high");
   a_ack_start: assert property (p_ack_start)
      else $error("acknowledge outside clock low in two-wire mode");
   a_ack_len: assert property (p_ack_len)
      else $error("acknowledge length wrong");
   a_ack_release: assert property (p_ack_release)
      else $error("acknowledge released with clock high");
   a_ack_slot: assert property (p_ack_slot)
      else $error("acknowledge not after eighth bit");
   a_sck_in_frame: assert property (p_sck_in_frame)
      else $error("serial clock edge outside select");
   a_sck_data: assert property (p_sck_data)
      else $error("data changed at clock edge");
   a_word_len: assert property (p_word_len)
      else $error("three-wire word not 32 bits");
   a_i2c_len: assert property (p_i2c_len)
      else $error("two-wire frame length wrong");
   a_ack_host_off: assert property (p_ack_host_off)
      else $error("host drove data during acknowledge");
endmodule // ssc_link_monitor

// [dv/ssc_tb_top.sv]
`timescale 1ns/1ps
module ssc_tb_top
   import ssc_pkg::*;
;
   typedef struct packed {
      logic [3:0]       route;
      logic [REG_W-1:0] val;
   } ssc_exp_t;
   localparam logic [6:0] DEV_ADDR = I2C_BASE_ADDR + 7'h03;
   logic             clk;
   logic             resetn;
   logic             cyc;
   logic             stb;
   logic             we;
   logic [7:0]       adr;
   logic [3:0]       sel;
   logic [31:0]      dat_w;
   logic [31:0]      wb_dat_r;
   logic             wb_ack;
   logic [REG_W-1:0] dev_reg [5];
   logic [REG_W-1:0] cur [5];
   logic [REG_W-1:0] freq_hz;
   logic             upd;
   logic             rsv;
   logic             fq_due;
   logic [31:0]      rd;
   ssc_exp_t         exp_q [$];
   ssc_exp_t         e;
   int               err_total;
   int               samples_checked;
   int               cyc_cnt;

   ssc_link_if lk ();
   ssc_host i_ssc_host (.clk(clk), .resetn(resetn), .link(lk.host), .wb_cyc(cyc), .wb_stb(stb), .wb_we(we),
      .wb_adr(adr), .wb_sel(sel), .wb_dat_w(dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack));
   ssc_dev #(.ADDR_VARIANT(2'h3)) i_ssc_dev (.clk(clk), .resetn(resetn), .link(lk.dev),
      .start_hz(dev_reg[1]), .stop_hz(dev_reg[2]), .step_hz(dev_reg[3]), .ref_hz(dev_reg[4]),
      .channel_num(dev_reg[0]), .freq_hz(freq_hz), .update(upd), .reserved_code(rsv));
   ssc_link_monitor i_ssc_link_monitor (.clk(clk), .resetn(resetn),
      .host_sel_data_oe_n(lk.host_sel_data_oe_n), .dev_sel_data_o(lk.dev_sel_data_o),
      .dev_sel_data_oe_n(lk.dev_sel_data_oe_n), .select_or_i2c_data_pin(lk.select_or_i2c_data_pin),
      .serial_in_or_i2c_clock_pin(lk.serial_in_or_i2c_clock_pin),
      .serial_clock_or_mode_pin(lk.serial_clock_or_mode_pin));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic fail(input string m);
      err_total++;
      $display("[FAIL] %0t %s", $time, m);
   endtask

   task automatic chk_val(input logic [REG_W-1:0] g, input logic [REG_W-1:0] x);
      samples_checked++;
      if (g !== x) fail("register value");
   endtask

   task automatic chk_bus(input logic [31:0] g, input logic [31:0] x);
      samples_checked++;
      if (g !== x) fail("bus value");
   endtask

   task complete_run;
      $display("checked %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   function automatic logic [REG_W-1:0] scale(input logic [23:0] v, input logic [3:0] x);
      logic [REG_W-1:0] s;
      s = {51'h0, v};
      for (int k = 0; k < 16; k++) if (k < x) s = s * 75'hA;
      return s;
   endfunction

   // Classic single Wishbone cycle
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hF;
      dat_w <= d;
      do @(posedge clk); while (wb_ack !== 1'b1);
      q = wb_dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   // One command through the host, expected result noted first
   task automatic send(input logic [31:0] c, input logic i2c, input logic [6:0] a, input logic hit);
      if (hit) exp_q.push_back({c[31:28], scale(c[23:0], c[27:24])});
      wb(1'b1, REG_CMD, c, rd);
      wb(1'b1, REG_CTRL, {17'h0, a, 6'h0, i2c, 1'b0}, rd);
      repeat (8) @(posedge clk);
      wb(1'b1, REG_CTRL, {17'h0, a, 6'h0, i2c, 1'b1}, rd);
      do wb(1'b0, REG_STATUS, 32'h0, rd); while (rd[0] !== 1'b0);
      chk_bus({30'h0, rd[1], 1'b0}, {30'h0, ~hit, 1'b0});
      for (int k = 0; k < 40 && exp_q.size() != 0; k++) @(posedge clk);
      if (exp_q.size() != 0) fail("no update");
   endtask

   // Result watcher
   always @(posedge clk) begin
      if (fq_due) begin
         chk_val(freq_hz, cur[1] + cur[0] * cur[3]);
      end
      fq_due = 1'b0;
      if (resetn && (upd === 1'b1 || rsv === 1'b1)) begin
         if (exp_q.size() == 0) begin
            fail("stray result");
         end else begin
            e = exp_q.pop_front();
            chk_bus({31'h0, rsv}, {31'h0, e.route > 4'h4});
            if (e.route < 4'h5) cur[e.route] = e.val;
            for (int k = 0; k < 5; k++) begin
               chk_val(dev_reg[k], cur[k]);
            end
            fq_due = 1'b1;
         end
      end
   end

   always @(posedge clk) begin
      cyc_cnt++;
      if (cyc_cnt == 90000) begin
         fail("timeout");
         complete_run();
      end
   end

   initial begin
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      sel = 4'h0;
      dat_w = 32'h0;
      resetn = 1'b0;
      fq_due = 1'b0;
      err_total = 0;
      samples_checked = 0;
      cyc_cnt = 0;
      cur = '{CHANNEL_RST, START_RST, STOP_RST, STEP_RST, REF_RST};
      rd = $urandom(32'h483E9A35);
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      for (int k = 0; k < 5; k++) chk_val(dev_reg[k], cur[k]);
      chk_val(freq_hz, START_RST);
      $display("test reset done");
      for (int r = 0; r < 6; r++) begin
         send({(r == 5) ? 4'($urandom_range(15, 5)) : 4'(r), 4'($urandom_range(15, 0)), 24'($urandom)},
              1'b0, 7'h00, 1'b1);
      end
      $display("test three_wire done");
      for (int r = 0; r < 2; r++) begin
         send({4'(r * 4), 4'($urandom_range(15, 0)), 24'($urandom)},
              1'b1, DEV_ADDR, 1'b1);
      end
      send({4'h1, 4'h0, 24'h000001}, 1'b1, I2C_BASE_ADDR, 1'b0);
      $display("test two_wire done");
      wb(1'b1, REG_STATUS, 32'h2, rd);
      wb(1'b0, REG_STATUS, 32'h0, rd);
      chk_bus(rd, 32'h0);
      wb(1'b0, 8'h0C, 32'h0, rd);
      chk_bus(rd, 32'h0);
      wb(1'b0, REG_CTRL, 32'h0, rd);
      chk_bus(rd, {17'h0, I2C_BASE_ADDR, 6'h0, 2'h2});
      wb(1'b0, REG_CMD, 32'h0, rd);
      chk_bus(rd, 32'h1000_0001);
      $display("test bus done");
      complete_run();
   end
endmodule // ssc_tb_top
